// file: rtl/stamp_pkg.sv
// Package of register map, field layout and constants for the frame timestamp unit
package stamp_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFF_EVENT_FLAGS = 12'h004;	// Interrupt event flags, write one to clear
	localparam logic [11:0] OFF_EVENT_MASK  = 12'h008;	// Interrupt event mask
	localparam logic [11:0] OFF_CONTROL     = 12'h00C;	// Control: precision-time enable
	localparam logic [11:0] OFF_HOLDING     = 12'h010;	// Transmit timestamp holding
	localparam logic [11:0] OFF_TIMER       = 12'h014;	// Live timer value
	localparam logic [11:0] OFF_TIMER_CMP   = 12'h018;	// Timer event compare value
	// ==========================================================
	// Field positions
	localparam int BIT_STAMP_AVAIL  = 0;	// Timestamp available flag
	localparam int BIT_TIMER_EVENT  = 1;	// Timer event flag
	localparam int BIT_PT_ENABLE    = 0;	// Precision-time enable in control
	localparam int BIT_STAT_REQ     = 5;	// Status bit: request was asserted
	localparam int FLAG_W           = 2;	// Number of event flags
	// ==========================================================
	// Reset values and responses
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;	// Reset of all words
	localparam logic [3:0]  RST_SEQ      = 4'h0;	// Reset of sequence count
	localparam logic [3:0]  SEQ_STEP     = 4'h1;	// Sequence increment
	localparam logic [31:0] TIMER_STEP   = 32'h0000_0001;	// Timer increment
	localparam logic [1:0]  RESP_OKAY    = 2'h0;	// AXI OKAY
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;	// AXI SLVERR for unmapped
	localparam logic [7:0]  RST_STATUS   = 8'h00;	// Reset of status byte
endpackage : stamp_pkg

// file: rtl/stamp_capture.sv
// Capture unit latching the timer on transmit and receive frame events
module stamp_capture
	import stamp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        enable_i,
	// Timer value
	input  wire logic [31:0] timer_i,
	// Transmit event
	input  wire logic        tx_frame_i,
	input  wire logic        tx_req_i,
	input  wire logic [7:0]  tx_stat_i,
	// Receive event
	input  wire logic        rx_sfd_i,
	// Results
	output logic      [31:0] tx_value_o,
	output logic      [3:0]  tx_seq_o,
	output logic      [7:0]  tx_stat_o,
	output logic             tx_valid_o,
	output logic             hold_load_o,
	output logic      [31:0] rx_value_o,
	output logic             rx_valid_o
);
	// ==========================================================
	// Sequence counter for transmitted frames
	logic [3:0] seq_reg;	// Next sequence number

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_reg <= RST_SEQ;
		end else if (ce_i && enable_i && tx_frame_i) begin
			seq_reg <= seq_reg + SEQ_STEP;	// (RULE13)
		end
	end

	// ==========================================================
	// Transmit capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_value_o  <= RST_WORD;
			tx_seq_o    <= RST_SEQ;
			tx_stat_o   <= RST_STATUS;
			tx_valid_o  <= 1'b0;
			hold_load_o <= 1'b0;
		end else if (ce_i) begin
			tx_valid_o  <= enable_i && tx_frame_i;	// (RULE1)
			hold_load_o <= enable_i && tx_frame_i && tx_req_i;	// (RULE5) (RULE7)
			if (enable_i && tx_frame_i) begin
				tx_value_o <= timer_i;	// (RULE3)
				tx_seq_o   <= seq_reg;
				tx_stat_o  <= tx_stat_i;
				tx_stat_o[BIT_STAT_REQ] <= tx_req_i;	// (RULE4)
			end
		end
	end

	// ==========================================================
	// Receive capture at delimiter detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_value_o <= RST_WORD;
			rx_valid_o <= 1'b0;
		end else if (ce_i) begin
			rx_valid_o <= enable_i && rx_sfd_i;
			if (enable_i && rx_sfd_i) begin
				rx_value_o <= timer_i;	// (RULE8)
			end
		end
	end
endmodule // stamp_capture

// file: rtl/mac_frame_timestamp_unit.sv
// Frame timestamp unit with AXI4-Lite registers and event interrupt
// How it works
// (RULE1) Stamp only while precision-time enable is one
// (RULE2) Client flags event frames with stamp request
// (RULE3) Every sent frame reports stamp, sequence, status
// (RULE4) Status bit five shows request was set
// (RULE5) Requested frames load holding, set available flag
// (RULE6) Software waits for flag, then reads holding
// (RULE7) Unrequested frames leave holding and flag alone
// (RULE8) Receive stamp latched at delimiter detection
// (RULE9) DMA copies receive stamp into descriptor
// (RULE10) Timer event flag shares the interrupt
// (RULE11) Interrupt when flag and mask both set
// (RULE12) Write one clears flag; reset clears all
// (RULE13) Free-running timer; four-bit wrapping sequence
module mac_frame_timestamp_unit
	import stamp_pkg::*;
(
	// Clock, reset, clock enable
	input  wire logic        REF_CLK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic        CLK_EN_I,
	// AXI4-Lite write address
	input  wire logic [11:0] S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	// AXI4-Lite write data
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	// AXI4-Lite write response
	output logic      [1:0]  S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	// AXI4-Lite read address
	input  wire logic [11:0] S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	// AXI4-Lite read data
	output logic      [31:0] S_AXI_RDATA_O,
	output logic      [1:0]  S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	// Transmit side from client
	input  wire logic        TX_FRAME_I,
	input  wire logic        TX_STAMP_REQUEST_I,
	input  wire logic [7:0]  TX_STATUS_I,
	// Transmit report
	output logic      [31:0] TX_STAMP_VALUE_O,
	output logic      [3:0]  TX_STAMP_SEQUENCE_O,
	output logic      [7:0]  TX_STAMP_STATUS_O,
	output logic             TX_STAMP_VALID_O,
	// Receive side
	input  wire logic        RX_SFD_I,
	output logic      [31:0] RX_STAMP_VALUE_O,
	output logic             RX_STAMP_VALID_O,
	// Shared interrupt
	output logic             IRQ_O
);
	import stamp_pkg::*;

	// ==========================================================
	// State
	// Everything below moves only while the clock enable is high;
	// a low enable freezes timer, flags, bus replies and captures alike
	logic [31:0]       timer_reg;	// Free-running timer
	logic [31:0]       cmp_reg;	// Timer event compare
	logic              enable_reg;	// Precision-time enable
	logic [31:0]       holding_reg;	// Transmit stamp holding
	logic [FLAG_W-1:0] flags_reg;	// Event flags
	logic [FLAG_W-1:0] mask_reg;	// Event mask
	logic [FLAG_W-1:0] flags_next;	// Flags after this cycle
	logic              hold_load;	// Requested frame captured
	logic [31:0]       tx_value;	// Captured transmit stamp
	logic              timer_hit;	// Timer reached compare

	// ==========================================================
	// AXI write handshake state
	// Each half is held once taken, so address and data may come in either order;
	// the response waits until both halves are in and no earlier answer is pending
	logic        aw_held_reg;	// Write address captured
	logic        w_held_reg;	// Write data captured
	logic [11:0] aw_addr_reg;	// Captured write address
	logic [31:0] w_data_reg;	// Captured write data
	logic [3:0]  w_strb_reg;	// Captured strobes
	logic        wr_fire;	// Both halves present, do write

	// ==========================================================
	// Merge strobed bytes into an old word
	// Used for the compare word, the only register that honours every strobe
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Decode a mapped offset
	// Unmapped offsets answer with an error response and read as zero
	function automatic logic mapped(input logic [11:0] a);
		return (a == OFF_EVENT_FLAGS) || (a == OFF_EVENT_MASK) || (a == OFF_CONTROL) ||
			(a == OFF_HOLDING) || (a == OFF_TIMER) || (a == OFF_TIMER_CMP);
	endfunction

	// ==========================================================
	// Capture unit
	// Transmit and receive stamps hold the timer of the strobe cycle and appear one cycle after the client's strobe;
	// the capture unit also gates everything on the precision-time enable
	stamp_capture u_capture (
		.clk_i       (REF_CLK_I),
		.rst_i       (SYS_RST_I),
		.ce_i        (CLK_EN_I),
		.enable_i    (enable_reg),
		.timer_i     (timer_reg),
		.tx_frame_i  (TX_FRAME_I),
		.tx_req_i    (TX_STAMP_REQUEST_I),
		.tx_stat_i   (TX_STATUS_I),
		.rx_sfd_i    (RX_SFD_I),
		.tx_value_o  (tx_value),
		.tx_seq_o    (TX_STAMP_SEQUENCE_O),
		.tx_stat_o   (TX_STAMP_STATUS_O),
		.tx_valid_o  (TX_STAMP_VALID_O),
		.hold_load_o (hold_load),
		.rx_value_o  (RX_STAMP_VALUE_O),
		.rx_valid_o  (RX_STAMP_VALID_O)
	);
	// Stamp output comes from the capture flop; the holding copy stays internal
	assign TX_STAMP_VALUE_O = tx_value;

	// ==========================================================
	// Free-running timer
	// Wraps silently at the top; stamps are raw counts with no notion of seconds
	// Held at zero by reset; counting starts at the first edge after release
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			timer_reg <= RST_WORD;
		end else if (CLK_EN_I) begin
			timer_reg <= timer_reg + TIMER_STEP;	// (RULE13)
		end
	end

	// Compare hit raises the timer event once per pass of the counter
	assign timer_hit = enable_reg && (timer_reg == cmp_reg);	// (RULE10)

	// ==========================================================
	// Holding register, loaded only by requested frames
	// Software should read it only after the available flag is seen set;
	// a later requested frame overwrites it without warning
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			holding_reg <= RST_WORD;
		end else if (CLK_EN_I && hold_load) begin
			holding_reg <= tx_value;	// (RULE5) (RULE7)
		end
	end

	// ==========================================================
	// Write channel acceptance, either order
	// Ready pulses for one cycle only, so a master must hold valid until taken
	// Fire only when both halves are held and the last response is gone
	assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID_O;

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			aw_held_reg     <= 1'b0;
			w_held_reg      <= 1'b0;
			aw_addr_reg     <= 12'h000;
			w_data_reg      <= RST_WORD;
			w_strb_reg      <= 4'h0;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= RESP_OKAY;
		end else if (CLK_EN_I) begin
			// Ready pulses for one cycle when a half is free
			S_AXI_AWREADY_O <= !aw_held_reg && S_AXI_AWVALID_I && !S_AXI_AWREADY_O;
			S_AXI_WREADY_O  <= !w_held_reg && S_AXI_WVALID_I && !S_AXI_WREADY_O;
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA_I;
				w_strb_reg <= S_AXI_WSTRB_I;
			end
			// Response after both halves
			if (wr_fire) begin
				aw_held_reg    <= 1'b0;
				w_held_reg     <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O  <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
				// Response taken
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Software-written control registers
	// Enable, mask and compare; flags and holding live in their own processes
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			enable_reg <= 1'b0;
			mask_reg   <= '0;
			cmp_reg    <= RST_WORD;
		end else if (CLK_EN_I && wr_fire) begin
			unique case (aw_addr_reg)
				// Enable bit gates every capture in the capture unit
				OFF_CONTROL: begin
					if (w_strb_reg[0]) begin
						enable_reg <= w_data_reg[BIT_PT_ENABLE];	// (RULE1)
					end
				end
				// Mask bits follow the flag layout
				OFF_EVENT_MASK: begin
					if (w_strb_reg[0]) begin
						mask_reg <= w_data_reg[FLAG_W-1:0];
					end
				end
				OFF_TIMER_CMP: begin
					cmp_reg <= merge(cmp_reg, w_data_reg, w_strb_reg);
				end
				default: begin
					// Other offsets store nothing here
				end
			endcase
		end
	end

	// ==========================================================
	// Event flags: set wins over write-one-clear
	// A clear that lands in the same cycle as a new event loses, so no event
	// is ever lost between the status read and the clear
	always_comb begin
		flags_next = flags_reg;
		if (wr_fire && (aw_addr_reg == OFF_EVENT_FLAGS) && w_strb_reg[0]) begin
			flags_next = flags_next & ~w_data_reg[FLAG_W-1:0];	// (RULE12)
		end
		if (hold_load) begin
			flags_next[BIT_STAMP_AVAIL] = 1'b1;	// (RULE5)
		end
		if (timer_hit) begin
			flags_next[BIT_TIMER_EVENT] = 1'b1;	// (RULE10)
		end
	end

	// Flag register itself
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			flags_reg <= '0;	// (RULE12)
		end else if (CLK_EN_I) begin
			flags_reg <= flags_next;
		end
	end

	// ==========================================================
	// Interrupt output from a flop
	// Built from the next flag value so it rises together with the flag
	// Masking a set flag drops the line a cycle later; the flag itself stays
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			IRQ_O <= 1'b0;
		end else if (CLK_EN_I) begin
			IRQ_O <= |(flags_next & mask_reg);	// (RULE11)
		end
	end

	// ==========================================================
	// Read channel
	// One read at a time: address ready is held off while an answer stands
	// Data are chosen at the address handshake and held until taken
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= RST_WORD;
			S_AXI_RRESP_O   <= RESP_OKAY;
		end else if (CLK_EN_I) begin
			S_AXI_ARREADY_O <= S_AXI_ARVALID_I && !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
			if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RRESP_O  <= mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
				unique case (S_AXI_ARADDR_I)
					OFF_EVENT_FLAGS: S_AXI_RDATA_O <= {{(32-FLAG_W){1'b0}}, flags_reg};
					OFF_EVENT_MASK:  S_AXI_RDATA_O <= {{(32-FLAG_W){1'b0}}, mask_reg};
					OFF_CONTROL:     S_AXI_RDATA_O <= {31'h0000_0000, enable_reg};
					OFF_HOLDING:     S_AXI_RDATA_O <= holding_reg;	// (RULE6)
					OFF_TIMER:       S_AXI_RDATA_O <= timer_reg;
					OFF_TIMER_CMP:   S_AXI_RDATA_O <= cmp_reg;
					default:         S_AXI_RDATA_O <= RST_WORD;
				endcase
			end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
				// Answer taken, channel free again
				S_AXI_RVALID_O <= 1'b0;
			end
		end
	end
endmodule // mac_frame_timestamp_unit

// file: sim/stamp_sva.sv
// Checker of frame reports and bus answers at the unit's ports
module stamp_sva (
	// Clock and reset
	input wire logic        REF_CLK_I,
	input wire logic        SYS_RST_I,
	// Frame reports
	input wire logic        TX_FRAME_I,
	input wire logic        TX_STAMP_REQUEST_I,
	input wire logic [31:0] TX_STAMP_VALUE_O,
	input wire logic [3:0]  TX_STAMP_SEQUENCE_O,
	input wire logic [7:0]  TX_STAMP_STATUS_O,
	input wire logic        TX_STAMP_VALID_O,
	input wire logic        RX_SFD_I,
	input wire logic        RX_STAMP_VALID_O,
	// Bus handshakes
	input wire logic        S_AXI_AWVALID_I,
	input wire logic        S_AXI_WVALID_I,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Shared clock and reset
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// A frame followed by its report
	sequence frame_report; TX_FRAME_I ##1 TX_STAMP_VALID_O; endsequence
	report_cause_a: assert property (TX_STAMP_VALID_O |-> $past(TX_FRAME_I))
		else $error("report without frame");
	request_bit_a: assert property (frame_report |-> TX_STAMP_STATUS_O[5] == $past(TX_STAMP_REQUEST_I))
		else $error("status bit five wrong");
	value_hold_a: assert property (!TX_STAMP_VALID_O |-> $stable(TX_STAMP_VALUE_O))
		else $error("stamp moved without frame");
	seq_hold_a: assert property (!TX_STAMP_VALID_O |-> $stable(TX_STAMP_SEQUENCE_O))
		else $error("sequence moved without frame");
	rx_cause_a: assert property (RX_STAMP_VALID_O |-> $past(RX_SFD_I))
		else $error("receive stamp without delimiter");
	read_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |-> ##[1:2] S_AXI_RVALID_O)
		else $error("read answer late");
	read_stand_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read answer dropped");
	read_drop_a: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
		else $error("read answer repeated");
	write_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_WVALID_I |-> ##[1:8] S_AXI_BVALID_O)
		else $error("write answer late");
endmodule // stamp_sva
bind mac_frame_timestamp_unit stamp_sva chk (.REF_CLK_I, .SYS_RST_I, .TX_FRAME_I, .TX_STAMP_REQUEST_I,
	.TX_STAMP_VALUE_O, .TX_STAMP_SEQUENCE_O, .TX_STAMP_STATUS_O, .TX_STAMP_VALID_O, .RX_SFD_I,
	.RX_STAMP_VALID_O, .S_AXI_AWVALID_I, .S_AXI_WVALID_I, .S_AXI_BVALID_O, .S_AXI_ARVALID_I,
	.S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I);

// file: sim/client_model.sv
// Client and receive descriptor model facing the timestamp unit
module client_model (
	// Clock and bench commands
	input  wire logic        clk_i,
	input  wire logic        send_i,
	input  wire logic        flag_i,
	input  wire logic        sfd_i,
	// Receive report from the unit
	input  wire logic        rx_valid_i,
	input  wire logic [31:0] rx_value_i,
	// Frame lines and descriptor field
	output logic             frame_o = 1'b0,
	output logic             req_o = 1'b0,
	output logic       [7:0] stat_o = 8'h00,
	output logic             sfd_o = 1'b0,
	output logic      [31:0] desc_o = 32'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Request and status qualify only the frame cycle, so they toggle elsewhere
	always @(posedge clk_i) begin
		frame_o <= send_i;
		req_o <= send_i ? flag_i : ~req_o;
		stat_o <= send_i ? 8'hC3 : ~stat_o;
		sfd_o <= sfd_i;
	end
	// Copy each receive stamp into the descriptor
	always @(posedge clk_i) if (rx_valid_i === 1'b1) desc_o <= rx_value_i;
endmodule // client_model

// file: sim/testbench.sv
// Register and frame test of the timestamp unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import stamp_pkg::*;
	// ==========================================
	// Unit ports and bench state
	logic        REF_CLK_I = 1'b0, SYS_RST_I = 1'b1, CLK_EN_I = 1'b1;
	logic [11:0] S_AXI_AWADDR_I = 12'h0, S_AXI_ARADDR_I = 12'h0;
	logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O, TX_STAMP_VALUE_O, RX_STAMP_VALUE_O;
	logic [3:0]  S_AXI_WSTRB_I = 4'hF, TX_STAMP_SEQUENCE_O, ts, b;
	logic        S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
	logic        S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0, S_AXI_AWREADY_O, S_AXI_WREADY_O;
	logic        S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O, TX_STAMP_VALID_O, RX_STAMP_VALID_O;
	logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
	logic        TX_FRAME_I, TX_STAMP_REQUEST_I, RX_SFD_I, IRQ_O, send = 1'b0, flag = 1'b0, sfd = 1'b0;
	logic [7:0]  TX_STATUS_I, TX_STAMP_STATUS_O, st;
	logic [31:0] desc, rv, tv, a, h;
	int          failures = 0, n_checks = 0, tx_n = 0;
	always #20 REF_CLK_I = ~REF_CLK_I;
	mac_frame_timestamp_unit uut (.REF_CLK_I, .SYS_RST_I, .CLK_EN_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I,
		.S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O,
		.S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
		.S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .TX_FRAME_I, .TX_STAMP_REQUEST_I,
		.TX_STATUS_I, .TX_STAMP_VALUE_O, .TX_STAMP_SEQUENCE_O, .TX_STAMP_STATUS_O, .TX_STAMP_VALID_O,
		.RX_SFD_I, .RX_STAMP_VALUE_O, .RX_STAMP_VALID_O, .IRQ_O);
	client_model partner (.clk_i(REF_CLK_I), .send_i(send), .flag_i(flag), .sfd_i(sfd),
		.rx_valid_i(RX_STAMP_VALID_O), .rx_value_i(RX_STAMP_VALUE_O), .frame_o(TX_FRAME_I),
		.req_o(TX_STAMP_REQUEST_I), .stat_o(TX_STATUS_I), .sfd_o(RX_SFD_I), .desc_o(desc));
	// Keep the latest transmit report
	always @(posedge REF_CLK_I) if (TX_STAMP_VALID_O === 1'b1) begin
		tx_n++;
		tv = TX_STAMP_VALUE_O;
		ts = TX_STAMP_SEQUENCE_O;
		st = TX_STAMP_STATUS_O;
	end
	// Verdict and end of run
	task automatic tally_and_finish;
		if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic hang;
		failures++;
		$display("Error at %0t: bus wait ran out", $time);
		tally_and_finish;
	endtask
	// Bus write: both halves offered together, each released when taken
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		int i;
		@(posedge REF_CLK_I);
		S_AXI_AWADDR_I <= ad;
		S_AXI_WDATA_I <= d;
		S_AXI_AWVALID_I <= 1'b1;
		S_AXI_WVALID_I <= 1'b1;
		S_AXI_BREADY_I <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge REF_CLK_I);
			if (S_AXI_AWREADY_O === 1'b1) S_AXI_AWVALID_I <= 1'b0;
			if (S_AXI_WREADY_O === 1'b1) S_AXI_WVALID_I <= 1'b0;
			if (S_AXI_BVALID_O === 1'b1) break;
		end
		if (i == 64) hang;
		S_AXI_BREADY_I <= 1'b0;
		chk(32'(S_AXI_BRESP_O), 32'(RESP_OKAY));
	endtask
	// Bus read: ready offered with the address and held until the answer
	task automatic rd(input logic [11:0] ad);
		int i;
		@(posedge REF_CLK_I);
		S_AXI_ARADDR_I <= ad;
		S_AXI_ARVALID_I <= 1'b1;
		S_AXI_RREADY_I <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge REF_CLK_I);
			if (S_AXI_ARREADY_O === 1'b1) S_AXI_ARVALID_I <= 1'b0;
			if (S_AXI_RVALID_O === 1'b1) break;
		end
		if (i == 64) hang;
		rv = S_AXI_RDATA_O;
		S_AXI_RREADY_I <= 1'b0;
		chk(32'(S_AXI_RRESP_O), 32'((ad == 12'h100) ? RESP_SLVERR : RESP_OKAY));
	endtask
	task automatic rdc(input logic [11:0] ad, input logic [31:0] e);
		rd(ad);
		chk(rv, e);
	endtask
	// One frame or delimiter, spaced five cycles from the next
	task automatic ev(input logic t, input logic f);
		@(posedge REF_CLK_I);
		send <= t;
		sfd <= !t;
		flag <= f;
		@(posedge REF_CLK_I);
		send <= 1'b0;
		sfd <= 1'b0;
		repeat (3) @(posedge REF_CLK_I);
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge REF_CLK_I);
		SYS_RST_I <= 1'b0;
		rdc(OFF_EVENT_FLAGS, 32'h0);
		rdc(OFF_EVENT_MASK, 32'h0);
		rdc(12'h100, 32'h0);
		ev(1'b1, 1'b1);
		chk(32'(tx_n), 32'h0);
		ev(1'b0, 1'b0);
		chk(desc, 32'h0);
		rdc(OFF_HOLDING, 32'h0);
		wr(OFF_CONTROL, 32'h1);
		wr(OFF_EVENT_MASK, 32'h1);
		ev(1'b1, 1'b1);
		a = tv;
		h = tv;
		b = ts;
		chk(32'(st), 32'hE3);
		ev(1'b1, 1'b0);
		chk(tv - a, 32'h5);
		chk(32'(ts), 32'(b + 4'h1));
		chk(32'(st), 32'hC3);
		chk(32'(tx_n), 32'h2);
		rdc(OFF_EVENT_FLAGS, 32'h1);
		rdc(OFF_HOLDING, h);
		chk(32'(IRQ_O), 32'h1);
		wr(OFF_EVENT_MASK, 32'h0);
		repeat (2) @(posedge REF_CLK_I);
		chk(32'(IRQ_O), 32'h0);
		wr(OFF_EVENT_FLAGS, 32'h0);
		rdc(OFF_EVENT_FLAGS, 32'h1);
		wr(OFF_EVENT_FLAGS, 32'h1);
		rdc(OFF_EVENT_FLAGS, 32'h0);
		ev(1'b0, 1'b0);
		a = desc;
		ev(1'b0, 1'b0);
		chk(desc - a, 32'h5);
		b = ts;
		repeat (16) ev(1'b1, 1'b0);
		chk(32'(ts), 32'(b));
		rdc(OFF_EVENT_FLAGS, 32'h0);
		rdc(OFF_HOLDING, h);
		rd(OFF_TIMER);
		wr(OFF_TIMER_CMP, rv + 32'hC8);
		repeat (250) @(posedge REF_CLK_I);
		rdc(OFF_EVENT_FLAGS, 32'h2);
		wr(OFF_EVENT_MASK, 32'h2);
		repeat (2) @(posedge REF_CLK_I);
		chk(32'(IRQ_O), 32'h1);
		rd(OFF_TIMER);
		a = rv;
		CLK_EN_I <= 1'b0;
		repeat (10) @(posedge REF_CLK_I);
		CLK_EN_I <= 1'b1;
		rd(OFF_TIMER);
		chk(rv - a, 32'h4);
		SYS_RST_I <= 1'b1;
		repeat (2) @(posedge REF_CLK_I);
		SYS_RST_I <= 1'b0;
		rdc(OFF_EVENT_FLAGS, 32'h0);
		rdc(OFF_CONTROL, 32'h0);
		tally_and_finish;
	end
endmodule // testbench
